/* core/gltc_top.sv */
// guard lock teach control: teach-in, lock drive, safety outputs, leds, ahb-lite registers
//
// Overview of operation
// [RL1] actuator after supply cycle starts teach, led pattern
// [RL2] after ten seconds yellow flashes at 3 Hz
// [RL3] no power-off in five minutes: abort, five red
// [RL4] redetect after power-up activates and stores code
// [RL5] one-time variant refuses any later teach-in
// [RL6] repeatable variant allows unlimited teach-in
// [RL7] new learned code replaces the previous code
// [RL8] repeatable learn inhibits safety outputs ten minutes
// [RL9] green flashes until inhibit over and actuator seen
// [RL10] power loss during inhibit restarts full period
// [RL11] handle in intermediate position prevents locking
// [RL12] power-to-unlock: control high means unlock
// [RL13] power-to-lock: control high means lock
// [RL14] lock monitoring: unlock disables both safety outputs
// [RL15] lock monitoring: relock with actuator re-enables outputs
// [RL16] door monitoring: only opening disables outputs
// [RL17] green supply, yellow state, red fault leds
// [RL18] missing safety input: green 1 Hz, yellow by guard
// [RL19] flash and interval counters cleared at power-up
// [RL20] safety outputs off throughout teach-in sequence
`timescale 1ns/1ns
`include "gltc_cfg.svh"

module gltc_top
	import gltc_pkg::*;
#(
	parameter int CYC_PER_SEC = `GLTC_CLK_HZ
)
(
	input  wire logic                    CORE_CLK_IN,
	input  wire logic                    RST_B_IN,
	input  wire logic                    SUPPLY_OK_IN,
	input  wire logic                    ACTUATOR_PRESENT_IN,
	input  wire logic [`GLTC_CODE_W-1:0] ACTUATOR_CODE_IN,
	input  wire logic                    HANDLE_DEFINED_IN,
	input  wire logic                    DOOR_CLOSED_IN,
	input  wire logic                    SOLENOID_CTRL_IN,
	input  wire logic                    FIRST_SAFETY_INPUT_IN,
	input  wire logic                    SECOND_SAFETY_INPUT_IN,
	input  wire logic                    HSEL_IN,
	input  wire logic [31:0]             HADDR_IN,
	input  wire logic [1:0]              HTRANS_IN,
	input  wire logic                    HWRITE_IN,
	input  wire logic [2:0]              HSIZE_IN,
	input  wire logic [31:0]             HWDATA_IN,
	input  wire logic                    HREADY_IN,
	output logic                         FIRST_SAFETY_OUTPUT_OUT,
	output logic                         SECOND_SAFETY_OUTPUT_OUT,
	output logic                         LOCK_DRIVE_OUT,
	output logic                         LED_GREEN_OUT,
	output logic                         LED_YELLOW_OUT,
	output logic                         LED_RED_OUT,
	output logic [31:0]                  HRDATA_OUT,
	output logic                         HREADYOUT_OUT,
	output logic                         HRESP_OUT
);

	// derived cycle counts; each flash half has its own prescaler, apart from the seconds one
	localparam logic [31:0] SEC_TOP   = 32'(CYC_PER_SEC);
	localparam logic [31:0] HALF1_TOP = 32'(CYC_PER_SEC / (2 * `GLTC_SLOW_FLASH_HZ));
	localparam logic [31:0] HALF3_TOP = 32'(CYC_PER_SEC / (2 * `GLTC_FAST_FLASH_HZ));
	localparam logic [`GLTC_SECS_W-1:0] TEACH_SECS    = `GLTC_SECS_W'(`GLTC_TEACH_WAIT_S);
	localparam logic [`GLTC_SECS_W-1:0] POWEROFF_SECS = `GLTC_SECS_W'(`GLTC_POWEROFF_MIN * 60);
	localparam logic [`GLTC_SECS_W-1:0] INHIBIT_SECS  = `GLTC_SECS_W'(`GLTC_INHIBIT_MIN * 60);
	localparam logic [3:0]  ABORT_EDGES = 4'(2 * `GLTC_ABORT_PULSES);

	localparam gltc_core_type CORE_RST = '{
		ctrl:    `GLTC_CTRL_RST,
		hready:  1'b1,
		state:   GLTC_OFF,
		default: '0
	};

	// wrapping counter step: bit 32 flags the wrap
	function automatic logic [32:0] next_count(input logic [31:0] c, input logic [31:0] top);
		logic [32:0] res;
		res = {1'b0, c + 32'h1};
		if (c >= top - 32'h1)
		begin
			res = 33'h100000000;
		end
		return res;
	endfunction

	gltc_core_type r;
	gltc_core_type n;

	// combinational next state of the whole block
	always_comb
	begin
		logic [`GLTC_PIN_W-1:0]  mask;
		logic [32:0]             c;
		logic                    w_sec;
		logic                    w1;
		logic                    w3;
		logic                    pw;
		logic                    act;
		logic [`GLTC_CODE_W-1:0] code;
		logic                    handle;
		logic                    door;
		logic                    sol;
		logic                    sin_ok;
		logic                    act_match;
		logic                    act_ok;
		logic                    lock_req;
		logic [2:0]              ev_set;
		logic [2:0]              ev_clr;
		logic [31:0]             rd;
		logic [31:0]             status;

		n = r;
		mask = '0;
		c = '0;
		w_sec = 1'b0;
		w1 = 1'b0;
		w3 = 1'b0;
		ev_set = '0;
		ev_clr = '0;
		rd = '0;
		status = '0;

		// three-stage pin capture; a change is taken once stages two and three agree
		n.s1 = {ACTUATOR_CODE_IN, SECOND_SAFETY_INPUT_IN, FIRST_SAFETY_INPUT_IN,
			SOLENOID_CTRL_IN, DOOR_CLOSED_IN, HANDLE_DEFINED_IN,
			ACTUATOR_PRESENT_IN, SUPPLY_OK_IN};
		n.s2 = r.s1;
		n.s3 = r.s2;
		mask = ~(r.s2 ^ r.s3);
		n.stab = (r.s3 & mask) | (r.stab & ~mask);

		pw = r.stab[`GLTC_PIN_SUPPLY];
		act = r.stab[`GLTC_PIN_ACT];
		code = r.stab[`GLTC_PIN_CODE_LO +: `GLTC_CODE_W];
		handle = r.stab[`GLTC_PIN_HANDLE];
		door = r.stab[`GLTC_PIN_DOOR];
		sol = r.stab[`GLTC_PIN_SOL];
		sin_ok = r.stab[`GLTC_PIN_SIN1] & r.stab[`GLTC_PIN_SIN2];
		n.pw_prev = pw;

		act_match = act & r.code_valid & (code == r.stored);
		act_ok = act & (~r.ctrl[`GLTC_CTRL_INDIV] | act_match);

		// prescalers for seconds and both flash rates
		c = next_count(r.sec_cnt, SEC_TOP);
		w_sec = c[32];
		n.sec_cnt = c[31:0];
		if (w_sec && (r.secs != '1))
		begin
			n.secs = r.secs + `GLTC_SECS_W'(1);
		end
		c = next_count(r.cnt1, HALF1_TOP);
		w1 = c[32];
		n.cnt1 = c[31:0];
		if (w1)
		begin
			n.ph1 = ~r.ph1;
		end
		c = next_count(r.cnt3, HALF3_TOP);
		w3 = c[32];
		n.cnt3 = c[31:0];
		if (w3)
		begin
			n.ph3 = ~r.ph3;
		end

		// teach-in sequence and normal operation
		case (r.state)
			GLTC_OFF:
			begin
				if (pw)
				begin
					n.first_detect = 1'b1;
					if (r.pend_valid)
					begin
						n.state = GLTC_CONFIRM; // RL4
					end
					else if (r.inhibit_pend)
					begin
						n.state = GLTC_INHIBIT; // RL10
					end
					else
					begin
						n.state = GLTC_RUN;
					end
				end
			end
			GLTC_RUN:
			begin
				if (act && r.first_detect)
				begin
					// only the first detection after a supply cycle may start teach-in
					n.first_detect = 1'b0;
					if (r.ctrl[`GLTC_CTRL_INDIV] && !act_match)
					begin
						if (!r.ctrl[`GLTC_CTRL_REPEAT] && r.learned)
						begin
							ev_set[`GLTC_EV_REFUSED] = 1'b1; // RL5
						end
						else
						begin
							n.pend_code = code; // RL6
							n.state = GLTC_TEACH; // RL1
						end
					end
				end
			end
			GLTC_TEACH:
			begin
				if (r.secs >= TEACH_SECS)
				begin
					n.state = GLTC_ASKOFF; // RL2
				end
			end
			GLTC_ASKOFF:
			begin
				if (r.secs >= POWEROFF_SECS)
				begin
					ev_set[`GLTC_EV_ABORT] = 1'b1; // RL3
					n.state = GLTC_ABORT; // RL3
				end
			end
			GLTC_ABORT:
			begin
				if (w3)
				begin
					n.red_cnt = r.red_cnt + 4'h1;
				end
				if (r.red_cnt >= ABORT_EDGES)
				begin
					n.state = GLTC_RUN;
				end
			end
			GLTC_CONFIRM:
			begin
				if (act && (code == r.pend_code))
				begin
					n.stored = r.pend_code; // RL7
					n.code_valid = 1'b1; // RL4
					n.learned = 1'b1;
					n.pend_valid = 1'b0;
					n.first_detect = 1'b0;
					ev_set[`GLTC_EV_LEARNED] = 1'b1;
					if (r.ctrl[`GLTC_CTRL_REPEAT])
					begin
						n.inhibit_pend = 1'b1; // RL8
						n.state = GLTC_INHIBIT; // RL8
					end
					else
					begin
						n.state = GLTC_RUN;
					end
				end
			end
			GLTC_INHIBIT:
			begin
				if ((r.secs >= INHIBIT_SECS) && act_match)
				begin
					n.inhibit_pend = 1'b0; // RL9
					n.state = GLTC_RUN; // RL9
				end
			end
			default:
			begin
				n.state = GLTC_OFF;
			end
		endcase

		// supply loss: a pending teach is armed only when the power-off was asked for
		if (!pw)
		begin
			if (r.state == GLTC_ASKOFF)
			begin
				n.pend_valid = 1'b1; // RL4
			end
			n.state = GLTC_OFF;
		end

		// interval counters restart on power-up and on each state change, flash counters on power-up only
		if (!pw || (n.state != r.state))
		begin
			n.sec_cnt = '0; // RL19
			n.secs = '0; // RL19
			n.red_cnt = '0;
		end
		if (!pw)
		begin
			n.cnt1 = '0; // RL19
			n.cnt3 = '0; // RL19
			n.ph1 = 1'b0;
			n.ph3 = 1'b0;
		end

		// lock drive follows the variant polarity; bolt needs handle, door and actuator
		lock_req = r.ctrl[`GLTC_CTRL_PTL] ? sol : ~sol; // RL12 RL13
		n.lock = pw & lock_req & door & act & handle; // RL11

		// both safety outputs share one enable; lock variant also needs the bolt
		n.sout = pw & (r.state == GLTC_RUN) & act_ok & door & sin_ok // RL20
			& (r.ctrl[`GLTC_CTRL_DOORMON] | r.lock); // RL14 RL15 RL16

		// indicator leds
		n.led_g = pw; // RL17
		n.led_r = 1'b0;
		n.led_y = 1'b0;
		case (r.state)
			GLTC_RUN:
			begin
				if (!sin_ok)
				begin
					n.led_g = r.ph1; // RL18
				end
				if (r.lock)
				begin
					n.led_y = 1'b1; // RL18
				end
				else if (door)
				begin
					n.led_y = r.ph1; // RL18
				end
			end
			GLTC_TEACH:
			begin
				n.led_g = 1'b0; // RL1
				n.led_r = 1'b1; // RL1
				n.led_y = r.ph1; // RL1
			end
			GLTC_ASKOFF:
			begin
				n.led_g = 1'b0;
				n.led_r = 1'b1;
				n.led_y = r.ph3; // RL2
			end
			GLTC_ABORT:
			begin
				n.led_r = (r.red_cnt < ABORT_EDGES) & ~r.red_cnt[0]; // RL3
			end
			GLTC_CONFIRM:
			begin
				n.led_y = r.ph1;
			end
			GLTC_INHIBIT:
			begin
				n.led_g = r.ph1; // RL9
			end
			default:
			begin
				n.led_g = 1'b0;
			end
		endcase

		// status word assembled from live state
		status[2:0] = r.state;
		status[3] = r.code_valid;
		status[4] = r.learned;
		status[5] = r.pend_valid;
		status[6] = r.inhibit_pend;
		status[7] = r.lock;
		status[8] = r.sout;
		status[9] = act_ok;
		status[10] = handle;
		status[11] = pw;

		// data phase: writes land here, using the address phase captured last cycle
		if (r.a_valid && r.a_write)
		begin
			if (r.a_addr == `GLTC_REG_CTRL)
			begin
				n.ctrl = HWDATA_IN[3:0];
			end
			else if (r.a_addr == `GLTC_REG_EVENT)
			begin
				ev_clr = HWDATA_IN[2:0];
			end
		end
		// a new event beats a clear in the same cycle
		n.ev = (r.ev & ~ev_clr) | ev_set;

		// address phase: read data is registered now so it stands in the data phase
		n.a_valid = HSEL_IN & HTRANS_IN[1] & HREADY_IN & (HSIZE_IN == 3'h2);
		n.a_write = HWRITE_IN;
		n.a_addr = HADDR_IN[7:0];
		if (HADDR_IN[31:8] != 24'h000000)
		begin
			rd = '0;
		end
		else if (HADDR_IN[7:0] == `GLTC_REG_CTRL)
		begin
			rd = {28'h0000000, r.ctrl};
		end
		else if (HADDR_IN[7:0] == `GLTC_REG_STATUS)
		begin
			rd = status;
		end
		else if (HADDR_IN[7:0] == `GLTC_REG_EVENT)
		begin
			rd = {29'h00000000, r.ev};
		end
		else if (HADDR_IN[7:0] == `GLTC_REG_CODE)
		begin
			rd = {24'h000000, r.stored};
		end
		if (HADDR_IN[31:8] != 24'h000000)
		begin
			n.a_valid = 1'b0; // unmapped high space: okay, ignored
		end
		n.hrdata = (n.a_valid && !HWRITE_IN) ? rd : 32'h00000000;
		n.hready = 1'b1; // zero wait states
	end

	// one register bank for all state
	always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN)
	begin
		if (!RST_B_IN)
		begin
			r <= CORE_RST;
		end
		else
		begin
			r <= n;
		end
	end

	// outputs straight from the state flops, except HRESP_OUT which is tied low
	assign FIRST_SAFETY_OUTPUT_OUT  = r.sout;
	assign SECOND_SAFETY_OUTPUT_OUT = r.sout;
	assign LOCK_DRIVE_OUT           = r.lock;
	assign LED_GREEN_OUT            = r.led_g;
	assign LED_YELLOW_OUT           = r.led_y;
	assign LED_RED_OUT              = r.led_r;
	assign HRDATA_OUT               = r.hrdata;
	assign HREADYOUT_OUT            = r.hready;
	assign HRESP_OUT                = 1'b0; // always okay

endmodule

/* core/gltc_cfg.svh */
// offsets, field positions, reset values and timing figures of the guard lock teach control
`ifndef GLTC_CFG_SVH
`define GLTC_CFG_SVH

// clock
`define GLTC_CLK_PERIOD_NS   40
`define GLTC_CLK_HZ          (1000000000 / `GLTC_CLK_PERIOD_NS)

// intervals in their own units
`define GLTC_TEACH_WAIT_S    10
`define GLTC_POWEROFF_MIN    5
`define GLTC_INHIBIT_MIN     10
`define GLTC_SLOW_FLASH_HZ   1
`define GLTC_FAST_FLASH_HZ   3
`define GLTC_ABORT_PULSES    5

// widths
`define GLTC_CODE_W          8
`define GLTC_PIN_W           15
`define GLTC_SECS_W          10

// synchronised pin vector positions
`define GLTC_PIN_SUPPLY      0
`define GLTC_PIN_ACT         1
`define GLTC_PIN_HANDLE      2
`define GLTC_PIN_DOOR        3
`define GLTC_PIN_SOL         4
`define GLTC_PIN_SIN1        5
`define GLTC_PIN_SIN2        6
`define GLTC_PIN_CODE_LO     7

// register byte offsets
`define GLTC_REG_CTRL        8'h00
`define GLTC_REG_STATUS      8'h04
`define GLTC_REG_EVENT       8'h08
`define GLTC_REG_CODE        8'h0c

// control fields and reset value
`define GLTC_CTRL_REPEAT     0
`define GLTC_CTRL_INDIV      1
`define GLTC_CTRL_PTL        2
`define GLTC_CTRL_DOORMON    3
`define GLTC_CTRL_RST        4'h3

// event fields
`define GLTC_EV_ABORT        0
`define GLTC_EV_LEARNED      1
`define GLTC_EV_REFUSED      2

`endif

/* core/gltc_pkg.sv */
// types shared by the guard lock teach control
`include "gltc_cfg.svh"
package gltc_pkg;

	// gray along off, run, teach, ask-off, confirm, inhibit, then abort
	typedef enum logic [2:0] {
		GLTC_OFF     = 3'h0,
		GLTC_RUN     = 3'h1,
		GLTC_TEACH   = 3'h3,
		GLTC_ASKOFF  = 3'h2,
		GLTC_CONFIRM = 3'h6,
		GLTC_INHIBIT = 3'h7,
		GLTC_ABORT   = 3'h5
	} gltc_state_type;

	typedef struct packed {
		logic [`GLTC_PIN_W-1:0]  s1;
		logic [`GLTC_PIN_W-1:0]  s2;
		logic [`GLTC_PIN_W-1:0]  s3;
		logic [`GLTC_PIN_W-1:0]  stab;
		logic                    pw_prev;
		gltc_state_type          state;
		logic [3:0]              ctrl;
		logic [2:0]              ev;
		logic [`GLTC_CODE_W-1:0] stored;
		logic                    code_valid;
		logic                    learned;
		logic [`GLTC_CODE_W-1:0] pend_code;
		logic                    pend_valid;
		logic                    inhibit_pend;
		logic                    first_detect;
		logic [31:0]             sec_cnt;
		logic [`GLTC_SECS_W-1:0] secs;
		logic [31:0]             cnt1;
		logic                    ph1;
		logic [31:0]             cnt3;
		logic                    ph3;
		logic [3:0]              red_cnt;
		logic                    lock;
		logic                    sout;
		logic                    led_g;
		logic                    led_y;
		logic                    led_r;
		logic                    a_valid;
		logic                    a_write;
		logic [7:0]              a_addr;
		logic [31:0]             hrdata;
		logic                    hready;
	} gltc_core_type;

endpackage

/* tb/gltc_ctl_model.sv */
// behavioural safety controller that drives the solenoid control input
`timescale 1ns/1ns
module gltc_ctl_model
(
	input  wire logic clk_in,
	input  wire logic lock_want_in,
	input  wire logic ptl_in,
	output logic      sol_out
);
	initial sol_out = 1'b0;
	// level changes only after an edge, like a plc output stage
	always @(posedge clk_in)
	begin
		sol_out <= ptl_in ? lock_want_in : !lock_want_in;
	end
endmodule

/* tb/gltc_monitor.sv */
// assertion checker on the guard lock teach control ports
`timescale 1ns/1ns
module gltc_monitor
(
	input wire logic CORE_CLK_IN,
	input wire logic RST_B_IN,
	input wire logic SUPPLY_OK_IN,
	input wire logic ACTUATOR_PRESENT_IN,
	input wire logic HANDLE_DEFINED_IN,
	input wire logic DOOR_CLOSED_IN,
	input wire logic FIRST_SAFETY_INPUT_IN,
	input wire logic FIRST_SAFETY_OUTPUT_OUT,
	input wire logic SECOND_SAFETY_OUTPUT_OUT,
	input wire logic LOCK_DRIVE_OUT,
	input wire logic LED_GREEN_OUT,
	input wire logic LED_RED_OUT
);
	default clocking cb @(posedge CORE_CLK_IN); endclocking
	default disable iff (!RST_B_IN);
	// eight cycles of a steady input cover the three-flop synchroniser and the output flop
	a_outs_equal: assert property (FIRST_SAFETY_OUTPUT_OUT == SECOND_SAFETY_OUTPUT_OUT)
		else $error("safety outputs differ");
	a_handle_nolock: assert property (!HANDLE_DEFINED_IN [*8] |-> !LOCK_DRIVE_OUT)
		else $error("locked with handle between positions");
	a_act_nolock: assert property (!ACTUATOR_PRESENT_IN [*8] |-> !LOCK_DRIVE_OUT && !FIRST_SAFETY_OUTPUT_OUT)
		else $error("lock or output without actuator");
	a_door_outs: assert property (!DOOR_CLOSED_IN [*8] |-> !FIRST_SAFETY_OUTPUT_OUT)
		else $error("output on with guard open");
	a_supply_dark: assert property (!SUPPLY_OK_IN [*8] |-> !LED_GREEN_OUT && !FIRST_SAFETY_OUTPUT_OUT)
		else $error("green or output without supply");
	a_input_outs: assert property (!FIRST_SAFETY_INPUT_IN [*8] |-> !FIRST_SAFETY_OUTPUT_OUT)
		else $error("output on with upstream chain open");
	// two cycles allow one clock of skew between led and output registers
	a_outs_green: assert property (FIRST_SAFETY_OUTPUT_OUT [*2] |-> LED_GREEN_OUT)
		else $error("output on while green not steady");
	a_red_outs: assert property (LED_RED_OUT [*2] |-> !FIRST_SAFETY_OUTPUT_OUT)
		else $error("output on during teach or fault");
	c_teach: cover property (LED_RED_OUT && !LED_GREEN_OUT);
	c_locked: cover property (LOCK_DRIVE_OUT && FIRST_SAFETY_OUTPUT_OUT);
	c_unlocked_on: cover property (!LOCK_DRIVE_OUT && FIRST_SAFETY_OUTPUT_OUT);
endmodule

bind gltc_top gltc_monitor i_mon (.CORE_CLK_IN(CORE_CLK_IN), .RST_B_IN(RST_B_IN),
	.SUPPLY_OK_IN(SUPPLY_OK_IN), .ACTUATOR_PRESENT_IN(ACTUATOR_PRESENT_IN),
	.HANDLE_DEFINED_IN(HANDLE_DEFINED_IN), .DOOR_CLOSED_IN(DOOR_CLOSED_IN),
	.FIRST_SAFETY_INPUT_IN(FIRST_SAFETY_INPUT_IN),
	.FIRST_SAFETY_OUTPUT_OUT(FIRST_SAFETY_OUTPUT_OUT),
	.SECOND_SAFETY_OUTPUT_OUT(SECOND_SAFETY_OUTPUT_OUT), .LOCK_DRIVE_OUT(LOCK_DRIVE_OUT),
	.LED_GREEN_OUT(LED_GREEN_OUT), .LED_RED_OUT(LED_RED_OUT));

/* tb/testbench.sv */
// self-checking bench for the guard lock teach control
`timescale 1ns/1ns
`include "gltc_cfg.svh"
module testbench
	import gltc_pkg::*;
;
	localparam logic [7:0] ctl_a = `GLTC_REG_CTRL;
	localparam logic [7:0] sts_a = `GLTC_REG_STATUS;
	localparam logic [7:0] evt_a = `GLTC_REG_EVENT;
	localparam logic [7:0] cod_a = `GLTC_REG_CODE;
	logic        clk = 1'b0, rst_b = 1'b0, sup = 1'b0, act = 1'b0, hnd = 1'b1, door = 1'b1;
	logic        s1 = 1'b1, s2 = 1'b1, want = 1'b1, ptl = 1'b0, hsel = 1'b0, hwr = 1'b0;
	logic [7:0]  code = 8'h5a;
	logic [1:0]  htrans = 2'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
	wire logic   sol, o1, o2, lk, lg, ly, lr, hrdy, hresp;
	wire logic [31:0] hrdata;
	wire logic [2:0]  leds = {lr, ly, lg};
	int          fails = 0, n_tests = 0, cyc = 0;

	gltc_ctl_model i_ctl (.clk_in(clk), .lock_want_in(want), .ptl_in(ptl), .sol_out(sol));
	gltc_top #(.CYC_PER_SEC(60)) i_dut (.CORE_CLK_IN(clk), .RST_B_IN(rst_b),
		.SUPPLY_OK_IN(sup), .ACTUATOR_PRESENT_IN(act), .ACTUATOR_CODE_IN(code),
		.HANDLE_DEFINED_IN(hnd), .DOOR_CLOSED_IN(door), .SOLENOID_CTRL_IN(sol),
		.FIRST_SAFETY_INPUT_IN(s1), .SECOND_SAFETY_INPUT_IN(s2), .HSEL_IN(hsel),
		.HADDR_IN(haddr), .HTRANS_IN(htrans), .HWRITE_IN(hwr), .HSIZE_IN(3'h2),
		.HWDATA_IN(hwdata), .HREADY_IN(hrdy), .FIRST_SAFETY_OUTPUT_OUT(o1),
		.SECOND_SAFETY_OUTPUT_OUT(o2), .LOCK_DRIVE_OUT(lk), .LED_GREEN_OUT(lg),
		.LED_YELLOW_OUT(ly), .LED_RED_OUT(lr), .HRDATA_OUT(hrdata),
		.HREADYOUT_OUT(hrdy), .HRESP_OUT(hresp));

	always #20 clk = !clk;

	task automatic results();
		$display("comparisons %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// the ceiling sits above the long inhibit and abort waits
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 99000)
		begin
			fails++;
			results();
		end
	end

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			fails++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// one single word transfer; read data is taken at the edge ending the data phase
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel   <= 1'b1;
		htrans <= 2'h2;
		hwr    <= w;
		haddr  <= {24'h0, a};
		do @(posedge clk); while (hrdy !== 1'b1);
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hrdy !== 1'b1);
		rd = hrdata;
	endtask

	task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		chk(nm, rd & m, e);
	endtask

	// polls the state field under a bounded count of reads
	task automatic wait_st(input logic [2:0] s, input int n);
		for (int i = 0; i < n; i++)
		begin
			xfer(1'b0, sts_a, 32'h0);
			if (rd[2:0] === s)
				break;
		end
		chk("state", {29'h0, rd[2:0]}, {29'h0, s});
	endtask

	task automatic wt(input int n);
		repeat (n) @(posedge clk);
	endtask

	// counts led changes over a window; a steady flash gives an exact count
	task automatic tog(input int k, input int n, input int e, input string nm);
		int   c;
		logic p;
		c = 0;
		p = leds[k];
		repeat (n)
		begin
			@(posedge clk);
			if (leds[k] !== p)
				c++;
			p = leds[k];
		end
		chk(nm, c, e);
	endtask

	task automatic power_cycle();
		sup <= 1'b0;
		wt(10);
		sup <= 1'b1;
	endtask

	initial
	begin
		wt(2);
		rst_b <= 1'b1;
		@(posedge clk);
		rdchk("ctrl reset", ctl_a, 32'hf, 32'h3);
		rdchk("event reset", evt_a, 32'h7, 32'h0);
		rdchk("unmapped", 8'h10, 32'hffffffff, 32'h0);
		chk("okay resp", hresp, 32'h0);
		xfer(1'b1, cod_a, 32'hff);
		rdchk("code ro", cod_a, 32'hff, 32'h0);
		$display("test reset done");
		sup <= 1'b1;
		wt(10);
		act <= 1'b1;
		wait_st(GLTC_TEACH, 40);
		chk("teach green", lg, 32'h0);
		chk("teach red", lr, 32'h1);
		chk("teach out", o1, 32'h0);
		tog(1, 60, 2, "teach yellow");
		wait_st(GLTC_ASKOFF, 400);
		tog(1, 60, 6, "askoff yellow");
		wait_st(GLTC_ABORT, 9100);
		tog(2, 100, 9, "abort red");
		wait_st(GLTC_RUN, 100);
		rdchk("abort event", evt_a, 32'h1, 32'h1);
		rdchk("no code", sts_a, 32'h8, 32'h0);
		xfer(1'b1, evt_a, 32'h7);
		rdchk("event clear", evt_a, 32'h7, 32'h0);
		$display("test abort done");
		power_cycle();
		wait_st(GLTC_TEACH, 40);
		wait_st(GLTC_ASKOFF, 400);
		sup <= 1'b0;
		wt(10);
		rdchk("pending", sts_a, 32'h20, 32'h20);
		sup <= 1'b1;
		wait_st(GLTC_INHIBIT, 40);
		rdchk("code", cod_a, 32'hff, 32'h5a);
		rdchk("learn event", evt_a, 32'h2, 32'h2);
		chk("inhibit out", o1, 32'h0);
		tog(0, 60, 2, "inhibit green");
		wt(30000);
		power_cycle();
		wt(7000);
		rdchk("inhibit restart", sts_a, 32'h7, {29'h0, GLTC_INHIBIT});
		wait_st(GLTC_RUN, 15000);
		$display("test learn done");
		wt(10);
		chk("locked", lk, 32'h1);
		chk("out on", o1, 32'h1);
		chk("out pair", o2, 32'h1);
		chk("green on", lg, 32'h1);
		want <= 1'b0;
		wt(10);
		chk("ptu unlock", lk, 32'h0);
		chk("lockmon off", o1, 32'h0);
		hnd  <= 1'b0;
		want <= 1'b1;
		wt(10);
		chk("handle between", lk, 32'h0);
		hnd <= 1'b1;
		wt(10);
		chk("relock out", o1, 32'h1);
		ptl <= 1'b1;
		xfer(1'b1, ctl_a, 32'hf);
		wt(10);
		chk("ptl lock", lk, 32'h1);
		want <= 1'b0;
		wt(10);
		chk("ptl unlock", lk, 32'h0);
		chk("doormon on", o1, 32'h1);
		door <= 1'b0;
		wt(10);
		chk("door open", o1, 32'h0);
		door <= 1'b1;
		s1   <= 1'b0;
		wt(10);
		chk("no input red", lr, 32'h0);
		tog(0, 60, 2, "no input green");
		tog(1, 60, 2, "no input yellow");
		s1 <= 1'b1;
		$display("test lock done");
		ptl  <= 1'b0;
		xfer(1'b1, ctl_a, 32'h2);
		code <= 8'ha5;
		power_cycle();
		wt(20);
		rdchk("refused", evt_a, 32'h4, 32'h4);
		rdchk("kept code", cod_a, 32'hff, 32'h5a);
		rdchk("ctrl rw", ctl_a, 32'hf, 32'h2);
		wait_st(GLTC_RUN, 10);
		$display("test one-time done");
		results();
	end
endmodule
